/* File: design/burst_order.sv */
/*
 * column order within one burst: registered low column bits for a beat.
 * assumes: start, beat and length are steady in the cycle before the edge.
 */
`timescale 1ns/1ps
`default_nettype none
module burst_order
	import ddr_mode_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [2:0] startLow,
	input  wire logic [2:0] beat,
	input  wire logic [1:0] lenLog2,
	input  wire logic       interleave,
	output logic      [2:0] columnLow
);
	wire logic [2:0] mask;
	wire logic [2:0] seqOffset;
	wire logic [2:0] ilvOffset;
	wire logic [2:0] offset;
	wire logic [2:0] next_columnLow;

	assign mask = 3'((4'h1 << lenLog2) - 4'h1);
	assign seqOffset = 3'(startLow + beat);
	assign ilvOffset = startLow ^ beat;
	assign offset = interleave ? ilvOffset : seqOffset;
	// bits above the mask keep the block, so the burst wraps inside it
	assign next_columnLow = (startLow & ~mask) | (offset & mask);

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			columnLow <= 3'h0;
		else
			columnLow <= next_columnLow;
	end
endmodule
`default_nettype wire

/* File: design/ddr_mode_config.sv */
/*
 * mode and extended mode registers of a ddr sdram and the burst and read
 * latency behaviour they steer: column sequencing, first-data timing and
 * dll enable, reset and lock tracking.
 * assumes: command strobes are already decoded, one cycle each, synchronous
 * to clk_sys; the controller keeps to its own loading rules.
 */
`timescale 1ns/1ps
`default_nettype none
module ddr_mode_config
	import ddr_mode_pkg::*;
#(
	parameter int         COL_W    = 10,
	parameter logic       WIDE_X16 = 1'b1,
	parameter logic [7:0] DLL_LOCK = 8'(DLL_LOCK_CYCLES)
)
(
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              loadMode,
	input  wire logic              bank_select_low,
	input  wire logic              bank_select_high,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              readCmd,
	input  wire logic              writeCmd,
	input  wire logic [COL_W-1:0]  column,
	input  wire logic              selfRefreshExit,
	output logic      [3:0]        burstLengthBeats,
	output logic                   burst_order_select_bit,
	output logic      [2:0]        read_latency_setting,
	output logic                   reservedSetting,
	output logic                   dllEnabled,
	output logic                   dllResetPulse,
	output logic                   dllLocked,
	output logic                   reducedDrive,
	output logic                   burstActive,
	output logic                   burstIsRead,
	output logic                   burstLast,
	output logic      [COL_W-1:0]  burstColumn,
	output logic                   readDataFirst,
	output logic                   readDataFalling
);
	// ****************************************
	// decoding
	// ****************************************
	function automatic logic [1:0] lenLog2Of(input logic [2:0] code);
		case (code)
			BL_CODE_2: lenLog2Of = 2'h1;
			BL_CODE_4: lenLog2Of = 2'h2;
			BL_CODE_8: lenLog2Of = 2'h3;
			default:   lenLog2Of = 2'h0; // reserved
		endcase
	endfunction

	logic [6:0]         baseField;
	logic [1:0]         extField;
	logic [LOCK_W-1:0]  lockCount;
	logic               lockRun;
	burst_state_e       state;
	logic [2:0]         beat;
	logic [COL_W-1:0]   startCol;
	logic               startRead;
	logic               startFalling;
	logic [1:0]         burstLen;
	logic               burstIlv;
	logic [READ_LAT_WHOLE-1:0] latTaps;

	wire logic [1:0] bankSel;
	wire logic       baseWrite;
	wire logic       extWrite;
	wire logic [6:0] opField;
	wire logic       opReserved;
	wire logic       dllResetReq;
	wire logic [1:0] curLenLog2;
	wire logic       curLatOk;
	wire logic       curLatHalf;
	wire logic       lenOk;
	wire logic       readTake;
	wire logic       writeTake;
	wire logic       nextDllOff;
	wire logic       dllTurnOn;
	wire logic       lockStart;
	wire logic [2:0] lastBeat;
	wire logic       beatEnd;
	wire logic [2:0] columnLow;

	assign bankSel = {bank_select_high, bank_select_low};
	assign baseWrite = loadMode && (bankSel == SEL_BASE);
	assign extWrite = loadMode && (bankSel == SEL_EXT);
	assign opField = addr[OPM_MSB:OPM_LSB];
	assign opReserved = (opField != OPM_NORMAL) && (opField != OPM_DLL_RESET);
	assign dllResetReq = baseWrite && (opField == OPM_DLL_RESET);
	assign curLenLog2 = lenLog2Of(baseField[BL_MSB:BL_LSB]);
	assign curLatOk = (baseField[CL_MSB:CL_LSB] == CL_CODE_2)
		|| (baseField[CL_MSB:CL_LSB] == CL_CODE_25);
	assign curLatHalf = baseField[CL_MSB:CL_LSB] == CL_CODE_25;
	assign lenOk = curLenLog2 != 2'h0;
	// reserved length codes give no burst at all and reserved latency codes no read burst, rather than a guessed order
	assign readTake = readCmd && lenOk && curLatOk;
	assign writeTake = writeCmd && !readCmd && lenOk;

	// ****************************************
	// mode registers
	// ****************************************
	// the dll reset bit is never stored, which makes it self-clearing
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			baseField <= BASE_RESET;
		else if (baseWrite)
			baseField <= addr[6:0];
	end

	assign nextDllOff = extWrite ? addr[EXT_DLL_OFF_BIT]
		: (selfRefreshExit ? 1'b0 : extField[EXT_DLL_OFF_BIT]);
	assign dllTurnOn = extField[EXT_DLL_OFF_BIT] && !nextDllOff;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			extField <= EXT_RESET;
		else
		begin
			extField[EXT_DLL_OFF_BIT] <= nextDllOff;
			if (extWrite)
				extField[EXT_WEAK_BIT] <= addr[EXT_WEAK_BIT];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			reservedSetting <= 1'b0;
		else if (baseWrite)
			reservedSetting <= opReserved || (lenLog2Of(addr[BL_MSB:BL_LSB]) == 2'h0)
				|| ((addr[CL_MSB:CL_LSB] != CL_CODE_2)
				&& (addr[CL_MSB:CL_LSB] != CL_CODE_25));
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			burstLengthBeats <= 4'h0;
			burst_order_select_bit <= 1'b0;
			read_latency_setting <= 3'h0;
			dllEnabled <= 1'b1;
			reducedDrive <= 1'b0;
			dllResetPulse <= 1'b0;
		end
		else
		begin
			burstLengthBeats <= (curLenLog2 == 2'h0) ? 4'h0 : 4'(4'h1 << curLenLog2);
			burst_order_select_bit <= baseField[BT_BIT];
			read_latency_setting <= baseField[CL_MSB:CL_LSB];
			dllEnabled <= !extField[EXT_DLL_OFF_BIT];
			// narrow parts ignore the weak drive request
			reducedDrive <= WIDE_X16 && extField[EXT_WEAK_BIT];
			dllResetPulse <= dllResetReq;
		end
	end

	// ****************************************
	// dll lock tracking
	// ****************************************
	// a status only: reads are not blocked while the dll settles
	assign lockStart = dllResetReq || dllTurnOn;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			lockCount <= DLL_LOCK;
			lockRun <= 1'b1;
		end
		else if (lockStart)
		begin
			lockCount <= DLL_LOCK;
			lockRun <= 1'b1;
		end
		else if (lockRun)
		begin
			lockCount <= lockCount - 8'h1;
			lockRun <= lockCount != 8'h1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			dllLocked <= 1'b0;
		else
			dllLocked <= !lockRun && !extField[EXT_DLL_OFF_BIT];
	end

	// ****************************************
	// burst sequencing
	// ****************************************
	read_latency_pipe #(
		.DEPTH (READ_LAT_WHOLE)
	) u_lat (
		.clk_sys (clk_sys),
		.rst     (rst),
		.launch  (readTake),
		.taps    (latTaps)
	);

	assign lastBeat = 3'((4'h1 << burstLen) - 4'h1);
	assign beatEnd = beat == lastBeat;

	// a new read or write cuts off whatever burst is running
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state <= ST_IDLE;
			beat <= 3'h0;
		end
		else if (readTake)
		begin
			state <= ST_WAIT;
			beat <= 3'h0;
		end
		else if (writeTake)
		begin
			state <= ST_BEAT;
			beat <= 3'h0;
		end
		else
		begin
			case (state)
				ST_WAIT:
				begin
					if (latTaps[READ_LAT_WHOLE-2])
						state <= ST_BEAT;
				end
				ST_BEAT:
				begin
					beat <= 3'(beat + 3'h1);
					if (beatEnd)
						state <= ST_IDLE;
				end
				ST_IDLE:
					beat <= 3'h0;
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// length and order are frozen per burst so a later load cannot tear one
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			startCol <= '0;
			startRead <= 1'b0;
			startFalling <= 1'b0;
			burstLen <= 2'h1;
			burstIlv <= 1'b0;
		end
		else if (readTake || writeTake)
		begin
			startCol <= column;
			startRead <= readTake;
			startFalling <= readTake && curLatHalf;
			burstLen <= curLenLog2;
			burstIlv <= baseField[BT_BIT];
		end
	end

	burst_order u_order (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.startLow   (startCol[2:0]),
		.beat       (beat),
		.lenLog2    (burstLen),
		.interleave (burstIlv),
		.columnLow  (columnLow)
	);

	assign burstColumn = {startCol[COL_W-1:3], columnLow};

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			burstActive <= 1'b0;
			burstIsRead <= 1'b0;
			burstLast <= 1'b0;
			readDataFirst <= 1'b0;
			readDataFalling <= 1'b0;
		end
		else
		begin
			burstActive <= state == ST_BEAT;
			burstIsRead <= (state == ST_BEAT) && startRead;
			burstLast <= (state == ST_BEAT) && beatEnd;
			readDataFirst <= latTaps[READ_LAT_WHOLE-1] && (state == ST_BEAT);
			readDataFalling <= latTaps[READ_LAT_WHOLE-1] && startFalling;
		end
	end
endmodule
`default_nettype wire

/* File: design/read_latency_pipe.sv */
/*
 * shift line that carries a read launch across the whole-clock latency.
 * assumes: launch is a one-cycle pulse in the clk_sys domain.
 */
`timescale 1ns/1ps
`default_nettype none
module read_latency_pipe
	import ddr_mode_pkg::*;
#(
	parameter int DEPTH = READ_LAT_WHOLE
)
(
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             launch,
	output logic      [DEPTH-1:0] taps
);
	genvar i;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			taps[0] <= 1'b0;
		else
			taps[0] <= launch;
	end
	generate
		for (i = 1; i < DEPTH; i++)
		begin : g_stage
			always_ff @(posedge clk_sys)
			begin
				if (rst)
					taps[i] <= 1'b0;
				else
					taps[i] <= taps[i-1];
			end
		end
	endgenerate
endmodule
`default_nettype wire

/* File: shared/ddr_mode_pkg.sv */
/*
 * constants, field layouts and state codes for the mode and extended mode
 * register block of a ddr sdram device.
 * assumes: importing modules run on one clock and a synchronous reset.
 */
// Contract
// - burst lengths two, four and eight exist for sequential and interleaved order
// - a burst stays inside an aligned block of burst-length columns and wraps
// - block is chosen by column bits above 0, 1 or 2; low bits start
// - one programmed burst length serves reads and writes alike
// - burst order bit of the mode register picks sequential or interleaved
// - sequential counts up modulo length; interleaved is start xor beat index
// - read taken at edge n with latency m gives first data at n+m
// - latencies two and two and a half; the half lands on a falling edge
// - bank selects low one, high zero write the extended register, retained
// - self refresh exit enables the dll with no register write
// - reduced drive works only on the sixteen-bit variant
// - address bits 0-2 length, 3 type, 4-6 latency, 7-13 mode field
// - both bank selects low write the base register; dll reset self-clears
package ddr_mode_pkg;
	localparam int ADDR_W = 14;
	localparam int BL_LSB = 0;
	localparam int BL_MSB = 2;
	localparam int BT_BIT = 3;
	localparam int CL_LSB = 4;
	localparam int CL_MSB = 6;
	localparam int OPM_LSB = 7;
	localparam int OPM_MSB = 13;
	localparam int EXT_DLL_OFF_BIT = 0;
	localparam int EXT_WEAK_BIT = 1;
	localparam logic [2:0] BL_CODE_2 = 3'h1;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;
	localparam logic [2:0] CL_CODE_2 = 3'h2;
	localparam logic [2:0] CL_CODE_25 = 3'h6;
	localparam logic [6:0] OPM_NORMAL = 7'h00;
	localparam logic [6:0] OPM_DLL_RESET = 7'h02;
	localparam logic [1:0] SEL_BASE = 2'h0;
	localparam logic [1:0] SEL_EXT = 2'h1;
	localparam logic [6:0] BASE_RESET = 7'h00;
	localparam logic [1:0] EXT_RESET = 2'h0;
	// whole clocks of read latency; the half clock is a flag
	localparam int READ_LAT_WHOLE = 2;
	localparam int DLL_LOCK_CYCLES = 200;
	localparam int LOCK_W = 8;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_BEAT = 3'b100
	} burst_state_e;
endpackage

/* File: test/ddr_ctrl_model.sv */
/*
 * memory controller model: issues mode loads, reads, writes, refresh exit.
 * assumes: caller only loads between bursts and picks legal settings, except one load of a reserved length code.
 */
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_model
	import ddr_mode_pkg::*;
(
	input  wire logic              clk_sys,
	output logic                   loadMode,
	output logic                   bank_select_low,
	output logic                   bank_select_high,
	output logic      [ADDR_W-1:0] addr,
	output logic                   readCmd,
	output logic                   writeCmd,
	output logic      [9:0]        column,
	output logic                   selfRefreshExit
);
	// ****************
	// command tasks
	// ****************
	initial
	begin
		{loadMode, bank_select_low, bank_select_high, readCmd, writeCmd, selfRefreshExit} = 6'h00;
		addr = '0;
		column = '0;
	end
	// mode field is only ever normal or dll reset
	task automatic loadReg(input logic [1:0] sel, input logic [ADDR_W-1:0] op);
		@(posedge clk_sys);
		loadMode <= 1'b1;
		{bank_select_high, bank_select_low} <= sel;
		addr <= op;
		@(posedge clk_sys);
		loadMode <= 1'b0;
		// released lines do not keep the last value
		{bank_select_high, bank_select_low} <= ~sel;
		addr <= ~op;
	endtask
	task automatic cmd(input logic rd, input logic [9:0] col);
		@(posedge clk_sys);
		readCmd <= rd;
		writeCmd <= !rd;
		column <= col;
		@(posedge clk_sys);
		readCmd <= 1'b0;
		writeCmd <= 1'b0;
		column <= ~col;
	endtask
	task automatic srx();
		@(posedge clk_sys);
		selfRefreshExit <= 1'b1;
		@(posedge clk_sys);
		selfRefreshExit <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: test/ddr_mode_and_burst_config_tb.sv */
/*
 * self-checking bench of ddr_mode_config with random burst settings.
 * assumes: controller model drives every command input of the block.
 */
`timescale 1ns/1ps
`default_nettype none
module ddr_mode_and_burst_config_tb
	import ddr_mode_pkg::*;
;
	// ****************
	// bench
	// ****************
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	int nErrors = 0;
	int nTests = 0;
	wire loadMode, bank_select_low, bank_select_high, readCmd, writeCmd, selfRefreshExit;
	wire [ADDR_W-1:0] addr;
	wire [9:0] column, burstColumn;
	wire [3:0] burstLengthBeats;
	wire [2:0] read_latency_setting;
	wire burst_order_select_bit, reservedSetting, dllEnabled, dllResetPulse, dllLocked;
	wire reducedDrive, burstActive, burstIsRead, burstLast, readDataFirst, readDataFalling;
	ddr_mode_config #(.DLL_LOCK(8'h04)) dut (.*);
	ddr_ctrl_model u_ctrl (.*);
	// latency frequency limits are a pad-timing matter; the logic is cycle-true
	always #12.5 clk_sys = ~clk_sys;
	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
		nTests++;
		if (g !== e)
		begin
			nErrors++;
			$display("unexpected %s expected %h seen %h", name, e, g);
		end
	endtask
	function automatic logic [9:0] expCol(input logic [9:0] s, input logic [2:0] len,
		input logic ilv, input int k);
		logic [9:0] m;
		logic [9:0] o;
		m = 10'((1 << len) - 1);
		o = ilv ? (s ^ 10'(k)) : (s + 10'(k));
		return (s & ~m) | (o & m);
	endfunction
	task automatic burst(input logic rd, input logic [9:0] c, input logic [2:0] len,
		input logic ilv, input logic [2:0] lat);
		u_ctrl.cmd(rd, c);
		// writes show their first column one edge after the command, reads two
		repeat (rd ? 3 : 2) @(negedge clk_sys);
		for (int k = 0; k < (1 << len); k++)
		begin
			chk("burstActive", 1, burstActive);
			chk("burstIsRead", rd, burstIsRead);
			chk("readDataFirst", rd && k == 0, readDataFirst);
			chk("readDataFalling", rd && k == 0 && lat == CL_CODE_25, readDataFalling);
			chk("burstColumn", expCol(c, len, ilv, k), burstColumn);
			chk("burstLast", k == (1 << len) - 1, burstLast);
			@(negedge clk_sys);
		end
		chk("burstActive", 0, burstActive);
	endtask
	task automatic summarize();
		if (nErrors == 0 && nTests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		nErrors++;
		summarize();
	end
	initial
	begin
		logic [2:0] bl;
		logic [2:0] lat;
		logic [9:0] c;
		logic bt;
		logic dr;
		bl = 3'($urandom(32'h11d9));
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(negedge clk_sys);
		chk("dllEnabled", 1, dllEnabled);
		chk("burstLengthBeats", 0, burstLengthBeats);
		// loads only fall between bursts a dll reset load is followed by a normal one
		for (int i = 0; i < 24; i++)
		begin
			bl = 3'($urandom_range(3, 1));
			bt = 1'($urandom);
			lat = $urandom_range(1, 0) ? CL_CODE_25 : CL_CODE_2;
			c = 10'($urandom);
			dr = (i % 3 == 0);
			if (i < 4)
			begin
				bl = BL_CODE_8;
				bt = i[0];
				c = 10'h3fd;
			end
			u_ctrl.loadReg(SEL_BASE, {5'h00, dr, 1'b0, lat, bt, bl});
			@(negedge clk_sys);
			chk("dllResetPulse", dr, dllResetPulse);
			@(negedge clk_sys);
			chk("burstLengthBeats", 4'h1 << bl, burstLengthBeats);
			chk("burst_order_select_bit", bt, burst_order_select_bit);
			chk("read_latency_setting", lat, read_latency_setting);
			chk("reservedSetting", 0, reservedSetting);
			chk("dllLocked", !dr, dllLocked);
			burst(i < 4 ? 1'b1 : 1'($urandom), c, bl, bt, lat);
		end
		u_ctrl.loadReg(SEL_BASE, 14'h0020);
		@(negedge clk_sys);
		chk("reservedSetting", 1, reservedSetting);
		@(negedge clk_sys);
		chk("burstLengthBeats", 0, burstLengthBeats);
		u_ctrl.cmd(1'b1, 10'h005);
		repeat (3) @(negedge clk_sys) chk("burstActive", 0, burstActive);
		for (int v = 0; v < 4; v++)
		begin
			u_ctrl.loadReg(SEL_EXT, 14'(v));
			repeat (2) @(negedge clk_sys);
			chk("dllEnabled", !v[0], dllEnabled);
			chk("reducedDrive", v[1], reducedDrive);
		end
		u_ctrl.loadReg(2'h2, 14'h0000);
		repeat (2) @(negedge clk_sys);
		chk("dllEnabled", 0, dllEnabled);
		u_ctrl.srx();
		repeat (2) @(negedge clk_sys);
		chk("dllEnabled", 1, dllEnabled);
		u_ctrl.loadReg(SEL_BASE, 14'h0122);
		repeat (12) @(negedge clk_sys);
		chk("dllLocked", 1, dllLocked);
		summarize();
	end
endmodule
`default_nettype wire

/* File: test/ddr_mode_config_assertions.sv */
/*
 * port checker for the mode register block, bound to ddr_mode_config.
 * assumes: one clock, synchronous reset, controller keeps its load rules.
 */
`timescale 1ns/1ps
`default_nettype none
module ddr_mode_config_assertions
	import ddr_mode_pkg::*;
#(
	parameter int   COL_W    = 10,
	parameter logic WIDE_X16 = 1'b1
)
(
	input wire logic              clk_sys,
	input wire logic              rst,
	input wire logic              loadMode,
	input wire logic              bank_select_low,
	input wire logic              bank_select_high,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic              readCmd,
	input wire logic              writeCmd,
	input wire logic [COL_W-1:0]  column,
	input wire logic              selfRefreshExit,
	input wire logic [3:0]        burstLengthBeats,
	input wire logic              burst_order_select_bit,
	input wire logic [2:0]        read_latency_setting,
	input wire logic              dllEnabled,
	input wire logic              dllResetPulse,
	input wire logic              reducedDrive,
	input wire logic              burstActive,
	input wire logic              burstIsRead,
	input wire logic              burstLast,
	input wire logic [COL_W-1:0]  burstColumn,
	input wire logic              readDataFirst,
	input wire logic              readDataFalling
);
	// ****************
	// port relations
	// ****************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire baseLd = loadMode && !bank_select_low && !bank_select_high;
	wire extLd  = loadMode && bank_select_low && !bank_select_high;
	wire anyCmd = readCmd || writeCmd;
	wire latOk  = read_latency_setting == CL_CODE_2 || read_latency_setting == CL_CODE_25;
	wire readOk = readCmd && burstLengthBeats != 4'h0 && latOk;
	AST_BL: assert property (baseLd && !addr[2] && addr[1:0] != 2'h0
		|=> ##1 burstLengthBeats == 4'(1 << $past(addr[1:0], 2))) else $error("burst length wrong");
	AST_RSV: assert property (baseLd && addr[BL_MSB:BL_LSB] == 3'h0
		|=> ##1 burstLengthBeats == 4'h0) else $error("reserved length shown");
	AST_TYPE: assert property (baseLd
		|=> ##1 burst_order_select_bit == $past(addr[BT_BIT], 2)) else $error("order bit wrong");
	AST_LAT: assert property (baseLd
		|=> ##1 read_latency_setting == $past(addr[CL_MSB:CL_LSB], 2)) else $error("latency wrong");
	AST_DLLRST: assert property (baseLd && addr[OPM_MSB:OPM_LSB] == OPM_DLL_RESET
		|=> dllResetPulse) else $error("no dll reset pulse");
	AST_EXT: assert property (extLd ##1 (!loadMode && !selfRefreshExit)[*2]
		|-> reducedDrive == (WIDE_X16 && $past(addr[EXT_WEAK_BIT], 2))
		&& dllEnabled == !$past(addr[EXT_DLL_OFF_BIT], 2)) else $error("ext register wrong");
	AST_SRX: assert property (selfRefreshExit && !loadMode ##1 !loadMode
		|-> ##1 dllEnabled) else $error("dll not on after self refresh");
	AST_RD: assert property (readOk ##1 (!anyCmd)[*2] |=> readDataFirst && burstIsRead
		&& burstColumn == $past(column, 3)
		&& readDataFalling == ($past(read_latency_setting, 3) == CL_CODE_25))
		else $error("read first data wrong");
	AST_WR: assert property (writeCmd && !readCmd && burstLengthBeats == 4'h2
		##1 (!anyCmd)[*2]
		|-> burstActive && !burstIsRead && !burstLast && burstColumn == $past(column, 2)
		##1 burstLast && burstColumn == ($past(column, 3) ^ COL_W'(1))) else $error("write burst wrong");
	AST_BLOCK: assert property (burstActive && !burstLast && !anyCmd && !$past(readCmd)
		|=> burstColumn[COL_W-1:3] == $past(burstColumn[COL_W-1:3])) else $error("left block");
endmodule
bind ddr_mode_config ddr_mode_config_assertions #(.COL_W(COL_W), .WIDE_X16(WIDE_X16)) u_chk (.*);
`default_nettype wire
